// [design/gyoc_consts.vh]
// Constants for the gyro output and command controller
`ifndef GYOC_CONSTS_VH
`define GYOC_CONSTS_VH
// Register byte offsets
`define GYOC_REG_CTRL      12'h000
`define GYOC_REG_MODE      12'h004
`define GYOC_REG_SAMPLE    12'h008
`define GYOC_REG_TEMP      12'h00C
`define GYOC_REG_FAULT     12'h010
`define GYOC_REG_OUT_VAL   12'h014
`define GYOC_REG_OUT_AUX   12'h018
`define GYOC_REG_LASTERR   12'h01C
`define GYOC_REG_STATUS    12'h020
// Control fields
`define GYOC_CTRL_UNIT_LSB 0
`define GYOC_CTRL_TRIG_BIT 4
`define GYOC_CTRL_STAB_BIT 5
`define GYOC_CTRL_EXIT_BIT 6
`define GYOC_CTRL_XNRM_BIT 7
`define GYOC_CTRL_SAVE_BIT 8
`define GYOC_CTRL_DONE_BIT 9
// Output units
`define GYOC_UNIT_RATE     2'h0
`define GYOC_UNIT_INCR     2'h1
`define GYOC_UNIT_AVG      2'h2
`define GYOC_UNIT_INTEG    2'h3
// Modes
`define GYOC_MODE_INIT     2'h0
`define GYOC_MODE_NORMAL   2'h1
`define GYOC_MODE_MAINT    2'h2
// Datagram kinds
`define GYOC_DG_MEAS       3'h0
`define GYOC_DG_PART       3'h1
`define GYOC_DG_SERIAL     3'h2
`define GYOC_DG_CONFIG     3'h3
`define GYOC_DG_INFO       3'h4
// Characters
`define GYOC_CHR_CR        8'h0D
`define GYOC_CHR_N         8'h4E
`define GYOC_CHR_I         8'h49
`define GYOC_CHR_C         8'h43
`define GYOC_CHR_R         8'h52
// Status byte bit for stabilisation
`define GYOC_STAT_STAB_BIT 6
// Maintenance entry command text, first character in the top byte
`define GYOC_ENTRY_WORD    88'h53_45_52_56_49_43_45_4D_4F_44_45
`endif

// [design/gyoc_top.v]
// Gyro output formation, mode control and normal-mode command parser
//
// How it works
// - Incremental angle sums samples since last send
// - Angle is 24-bit two's complement, MSB first
// - Average rate is mean of interval samples
// - Filtered samples feed the averaging
// - Rate values are 24-bit, scaled 2^14
// - Integrated angle runs from reset, wraps silently
// - Integrated angle scaled like incremental angle
// - Temperature is 16-bit two's complement, MSB first
// - Counter holds sample count for incr/avg
// - Counter wraps per sample for rate/integ
// - Latency is 16-bit microseconds, MSB first
// - Maintenance entry first sends info listing
// - Maintenance keeps measuring, sends no datagrams
// - Reset in maintenance reloads flash configuration
// - Exit parameter picks init or normal mode
// - Status bits valid for one transmission only
// - Self-check faults feed the status byte
// - Last measurement-mode error is retained
// - Commands decoded only at carriage return
// - Five commands: N, I, C, R, entry word
// - No echo; ignore anything not exact
// - Special datagram replaces next measurement one
// - Angle during special datagram is dropped
// - Finish current datagram before entering maintenance
// - Bit 6 set during stabilisation after init
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`include "gyoc_consts.vh"

module gyoc_top #(
   parameter CMD_LEN = 11
) (
   // Clock and reset
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   // APB slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   output wire        pready_out,
   output wire        pslverr_out,
   output reg  [31:0] prdata_out,
   // Filtered internal samples
   input  wire        sample_valid_in,
   input  wire [23:0] sample_rate_in,
   // Received serial characters
   input  wire        rx_valid_in,
   input  wire [7:0]  rx_char_in,
   // Datagram sender handshake
   input  wire        tx_busy_in,
   output reg         tx_start_out,
   output reg  [2:0]  tx_kind_out,
   output reg         tx_stab_out,
   // Mode and configuration
   output reg  [1:0]  mode_out,
   output reg         cfg_reload_out,
   output reg         unit_reset_out
);

   // Apb handshake
   wire        wr_en;
   wire        rd_en;
   // Control and inputs held by software, last error captured by hardware
   reg  [9:0]  ctrl;
   reg  [15:0] temp_val;
   reg  [15:0] latency;
   reg  [7:0]  fault_now;
   reg  [7:0]  last_err;
   // Accumulators
   reg  [31:0] accum;
   reg  [23:0] integ;
   reg  [7:0]  count;
   reg  [23:0] last_rate;
   // Output snapshot
   reg  [23:0] out_val;
   reg  [7:0]  out_cnt;
   reg  [7:0]  out_status;
   // Parser
   reg  [7:0]  cmd_buf [0:CMD_LEN-1];
   reg  [3:0]  cmd_len;
   reg         cmd_over;
   reg  [2:0]  special_req;
   reg         maint_req;
   reg         in_special;
   reg         stab;
   integer     k;
   integer     m;

   wire [1:0]  unit      = ctrl[`GYOC_CTRL_UNIT_LSB+1:`GYOC_CTRL_UNIT_LSB];
   wire        send_trig = wr_en && (paddr_in == `GYOC_REG_CTRL)
                           && pwdata_in[`GYOC_CTRL_TRIG_BIT];
   wire        exit_cmd  = wr_en && (paddr_in == `GYOC_REG_CTRL)
                           && pwdata_in[`GYOC_CTRL_EXIT_BIT];
   wire        info_done = wr_en && (paddr_in == `GYOC_REG_CTRL)
                           && pwdata_in[`GYOC_CTRL_DONE_BIT];
   wire        is_cr     = rx_valid_in && (rx_char_in == `GYOC_CHR_CR);
   // Sum kept 32 bits wide so 255 full-scale rates cannot overflow
   wire [31:0] ang_step  = {{15{sample_rate_in[23]}}, sample_rate_in[23:7]};
   wire [31:0] rate_step = {{8{sample_rate_in[23]}}, sample_rate_in};
   wire [31:0] acc_step  = (unit == `GYOC_UNIT_AVG) ? rate_step : ang_step;

   // Mean of sum over n samples, truncated toward zero
   function [23:0] mean24;
      input [31:0] sum;
      input [7:0]  n;
      reg   [31:0] mag;
      reg   [31:0] q;
      begin
         mag = sum[31] ? (~sum + 32'h00000001) : sum;
         q = (n == 8'h00) ? 32'h00000000 : (mag / {24'h000000, n});
         mean24 = sum[31] ? (~q[23:0] + 24'h000001) : q[23:0];
      end
   endfunction

   // Match buffered text against the maintenance entry word
   function match_entry;
      input [8*11-1:0] text;
      begin
         match_entry = (text == `GYOC_ENTRY_WORD);
      end
   endfunction

   reg [8*11-1:0] flat;
   always @* begin
      flat = 88'h0;
      for (m = 0; m < 11; m = m + 1) begin
         flat[8*(10-m) +: 8] = cmd_buf[m];
      end
   end

   assign wr_en       = psel_in && penable_in && pwrite_in;
   assign rd_en       = psel_in && penable_in && !pwrite_in;
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && (paddr_in > `GYOC_REG_STATUS);

   // Register writes
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ctrl      <= 10'h000;
         temp_val  <= 16'h0000;
         latency   <= 16'h0000;
         fault_now <= 8'h00;
      end else if (wr_en) begin
         case (paddr_in)
            `GYOC_REG_CTRL:   ctrl      <= pwdata_in[9:0] & 10'h1B3;
            `GYOC_REG_TEMP: begin
               temp_val <= pwdata_in[15:0];
               latency  <= pwdata_in[31:16];
            end
            `GYOC_REG_FAULT:  fault_now <= pwdata_in[7:0];
            default:          ctrl      <= ctrl;
         endcase
      end
   end

   // Register reads
   always @* begin
      prdata_out = 32'h00000000;
      if (rd_en) begin
         case (paddr_in)
            `GYOC_REG_CTRL:    prdata_out = {22'h0, ctrl};
            `GYOC_REG_MODE:    prdata_out = {29'h0, in_special, mode_out};
            `GYOC_REG_TEMP:    prdata_out = {latency, temp_val};
            `GYOC_REG_FAULT:   prdata_out = {24'h0, fault_now};
            `GYOC_REG_OUT_VAL: prdata_out = {out_cnt, out_val};
            `GYOC_REG_OUT_AUX: prdata_out = {latency, temp_val};
            `GYOC_REG_LASTERR: prdata_out = {24'h0, last_err};
            `GYOC_REG_STATUS:  prdata_out = {24'h0, out_status};
            default:           prdata_out = 32'h00000000;
         endcase
      end
   end

   // Sample accumulation and output formation
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         accum      <= 32'h00000000;
         integ      <= 24'h000000;
         count      <= 8'h00;
         last_rate  <= 24'h000000;
         out_val    <= 24'h000000;
         out_cnt    <= 8'h00;
         out_status <= 8'h00;
         last_err   <= 8'h00;
      end else begin
         if (sample_valid_in) begin
            integ     <= integ + ang_step[23:0];
            last_rate <= sample_rate_in;
         end
         if (send_trig && mode_out == `GYOC_MODE_NORMAL && special_req == `GYOC_DG_MEAS) begin
            out_status <= fault_now | ({7'h0, stab} << `GYOC_STAT_STAB_BIT);
            out_cnt    <= (unit == `GYOC_UNIT_RATE || unit == `GYOC_UNIT_INTEG) ?
                          count : count;
            case (unit)
               `GYOC_UNIT_RATE:  out_val <= last_rate;
               `GYOC_UNIT_INCR:  out_val <= accum[23:0];
               `GYOC_UNIT_AVG:   out_val <= mean24(accum, count);
               default:          out_val <= integ;
            endcase
            accum <= sample_valid_in ? acc_step : 32'h00000000;
            if (unit == `GYOC_UNIT_INCR || unit == `GYOC_UNIT_AVG) begin
               count <= sample_valid_in ? 8'h01 : 8'h00;
            end else if (sample_valid_in) begin
               count <= count + 8'h01;
            end
         end else if (sample_valid_in) begin
            count <= count + 8'h01;
            if (in_special && unit == `GYOC_UNIT_INCR) begin
               accum <= 32'h00000000;
               count <= 8'h00;
            end else begin
               accum <= accum + acc_step;
            end
         end
         if (mode_out == `GYOC_MODE_NORMAL && fault_now != 8'h00) begin
            last_err <= fault_now;
         end
      end
   end

   // Command parser and mode control
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cmd_len        <= 4'h0;
         cmd_over       <= 1'b0;
         special_req    <= `GYOC_DG_MEAS;
         maint_req      <= 1'b0;
         in_special     <= 1'b0;
         stab           <= 1'b1;
         mode_out       <= `GYOC_MODE_INIT;
         tx_start_out   <= 1'b0;
         tx_kind_out    <= `GYOC_DG_MEAS;
         tx_stab_out    <= 1'b1;
         cfg_reload_out <= 1'b1;
         unit_reset_out <= 1'b0;
         for (k = 0; k < CMD_LEN; k = k + 1) begin
            cmd_buf[k] <= 8'h00;
         end
      end else begin
         tx_start_out   <= 1'b0;
         cfg_reload_out <= 1'b0;
         unit_reset_out <= 1'b0;
         tx_stab_out    <= stab;
         // Sender shows busy one cycle after the start pulse
         if (!tx_busy_in && !tx_start_out) begin
            in_special <= 1'b0;
         end
         if (wr_en && paddr_in == `GYOC_REG_CTRL && pwdata_in[`GYOC_CTRL_STAB_BIT]) begin
            stab <= 1'b0;
         end
         case (mode_out)
            `GYOC_MODE_INIT: begin
               if (info_done) begin
                  mode_out <= `GYOC_MODE_NORMAL;
               end
            end
            `GYOC_MODE_NORMAL: begin
               if (is_cr) begin
                  cmd_len  <= 4'h0;
                  cmd_over <= 1'b0;
                  if (!cmd_over && cmd_len == 4'h1) begin
                     case (cmd_buf[0])
                        `GYOC_CHR_N: special_req <= `GYOC_DG_PART;
                        `GYOC_CHR_I: special_req <= `GYOC_DG_SERIAL;
                        `GYOC_CHR_C: special_req <= `GYOC_DG_CONFIG;
                        `GYOC_CHR_R: begin
                           unit_reset_out <= 1'b1;
                           mode_out       <= `GYOC_MODE_INIT;
                           stab           <= 1'b1;
                        end
                        default:     special_req <= special_req;
                     endcase
                  end else if (!cmd_over && cmd_len == 4'd11 && match_entry(flat)) begin
                     maint_req <= 1'b1;
                  end
               end else if (rx_valid_in) begin
                  if (cmd_len == CMD_LEN[3:0]) begin
                     cmd_over <= 1'b1;
                  end else begin
                     cmd_buf[cmd_len] <= rx_char_in;
                     cmd_len          <= cmd_len + 4'h1;
                  end
               end
               if (send_trig) begin
                  tx_start_out <= 1'b1;
                  tx_kind_out  <= special_req;
                  in_special   <= (special_req != `GYOC_DG_MEAS);
                  special_req  <= `GYOC_DG_MEAS;
               end
               if (maint_req && !tx_busy_in && !tx_start_out && !send_trig) begin
                  maint_req    <= 1'b0;
                  mode_out     <= `GYOC_MODE_MAINT;
                  tx_start_out <= 1'b1;
                  tx_kind_out  <= `GYOC_DG_INFO;
               end
            end
            `GYOC_MODE_MAINT: begin
               if (exit_cmd) begin
                  if (pwdata_in[`GYOC_CTRL_XNRM_BIT]) begin
                     mode_out <= `GYOC_MODE_NORMAL;
                  end else begin
                     mode_out       <= `GYOC_MODE_INIT;
                     cfg_reload_out <= 1'b1;
                     stab           <= 1'b1;
                  end
               end
            end
            default: mode_out <= `GYOC_MODE_INIT;
         endcase
      end
   end

endmodule

// [tb/gyoc_top_asserts.sv]
// Port checker for the gyro output and command controller
`timescale 1ns/10ps
`include "gyoc_consts.vh"
module gyoc_chk (
   // Clock, reset and bus
   input wire        clk_sys_in,
   input wire        rst_n_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire        pslverr_out,
   input wire [31:0] prdata_out,
   // Link side and mode
   input wire        rx_valid_in,
   input wire [7:0]  rx_char_in,
   input wire        tx_busy_in,
   input wire        tx_start_out,
   input wire [2:0]  tx_kind_out,
   input wire        tx_stab_out,
   input wire [1:0]  mode_out,
   input wire        cfg_reload_out,
   input wire        unit_reset_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_trig;
      psel_in && penable_in && pwrite_in && paddr_in == `GYOC_REG_CTRL
         && pwdata_in[`GYOC_CTRL_TRIG_BIT] && mode_out == `GYOC_MODE_NORMAL;
   endsequence
   sequence s_pulse;
      tx_start_out ##1 !tx_start_out;
   endsequence
   property p_rst_state;
      $rose(rst_n_in) |-> cfg_reload_out && tx_stab_out && mode_out == `GYOC_MODE_INIT;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
   property p_unmapped;
      psel_in && penable_in && paddr_in > 12'h020 |-> pslverr_out;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_send;
      s_trig |=> s_pulse;
   endproperty
   a_send: assert property (p_send) else $error("send request gave no single pulse");
   property p_maint_quiet;
      mode_out == `GYOC_MODE_MAINT && tx_start_out |-> tx_kind_out == `GYOC_DG_INFO;
   endproperty
   a_maint_quiet: assert property (p_maint_quiet) else $error("datagram in maintenance");
   property p_entry_idle;
      $rose(mode_out == `GYOC_MODE_MAINT) |-> !$past(tx_busy_in);
   endproperty
   a_entry_idle: assert property (p_entry_idle) else $error("entry cut a datagram");
   property p_no_cr;
      rx_valid_in && rx_char_in != `GYOC_CHR_CR |=> !unit_reset_out;
   endproperty
   a_no_cr: assert property (p_no_cr) else $error("acted without terminator");
   property p_reset_cmd;
      unit_reset_out |-> ##[0:2] mode_out == `GYOC_MODE_INIT;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");
   property p_stab;
      $rose(mode_out == `GYOC_MODE_NORMAL) && $past(mode_out) == `GYOC_MODE_INIT |-> tx_stab_out;
   endproperty
   a_stab: assert property (p_stab) else $error("stabilising flag missing");
   property p_rdata_idle;
      !(psel_in && penable_in) |-> prdata_out == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
endmodule
bind gyoc_top gyoc_chk gyoc_chk_inst (.clk_sys_in, .rst_n_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .pslverr_out, .prdata_out, .rx_valid_in, .rx_char_in,
   .tx_busy_in, .tx_start_out, .tx_kind_out, .tx_stab_out, .mode_out, .cfg_reload_out,
   .unit_reset_out);

// [tb/gyoc_sender_model.sv]
// Datagram sender model standing on the serial side
`timescale 1ns/10ps
module gyoc_sender_model #(
   parameter LEN = 60
) (
   // Clock and reset
   input  wire       clk_sys_in,
   input  wire       rst_n_in,
   // Sender handshake
   input  wire       tx_start_in,
   input  wire [2:0] tx_kind_in,
   output reg        tx_busy_out,
   output reg  [2:0] last_kind_out,
   output reg  [7:0] sent_cnt_out
);
   integer left;
   // Long frames so commands can land mid-datagram
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         tx_busy_out   <= 1'b0;
         left          <= 0;
         last_kind_out <= 3'h7;
         sent_cnt_out  <= 8'h00;
      end else if (tx_start_in) begin
         tx_busy_out   <= 1'b1;
         left          <= LEN;
         last_kind_out <= tx_kind_in;
         sent_cnt_out  <= sent_cnt_out + 8'h01;
      end else if (left > 1) begin
         left <= left - 1;
      end else begin
         tx_busy_out <= 1'b0;
         left        <= 0;
      end
   end
endmodule

// [tb/gyoc_top_tb_top.sv]
// Self-checking bench for the gyro output and command controller
`timescale 1ns/10ps
`include "gyoc_consts.vh"
module gyoc_top_tb_top;
   reg         clk_sys_in = 1'b0;
   reg         rst_n_in = 1'b0;
   reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, s_vld = 1'b0, rx_vld = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0, rd;
   reg  [23:0] s_rate = 24'h0, acc, ang = 24'h0, tv [0:3];
   reg  [7:0]  rx_chr = 8'h00, c0;
   reg         err;
   wire        pready, pslverr, tx_busy, tx_start, tx_stab, cfg_reload, unit_reset;
   wire [31:0] prdata;
   wire [2:0]  tx_kind, last_kind;
   wire [1:0]  mode;
   wire [7:0]  sent_cnt;
   integer     error_cnt = 0, tests_run = 0, i, s;
   initial forever #2 clk_sys_in = ~clk_sys_in;
   gyoc_top gyoc_top_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
      .sample_valid_in(s_vld), .sample_rate_in(s_rate), .rx_valid_in(rx_vld),
      .rx_char_in(rx_chr), .tx_busy_in(tx_busy), .tx_start_out(tx_start),
      .tx_kind_out(tx_kind), .tx_stab_out(tx_stab), .mode_out(mode),
      .cfg_reload_out(cfg_reload), .unit_reset_out(unit_reset));
   gyoc_sender_model gyoc_sender_model_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .tx_start_in(tx_start), .tx_kind_in(tx_kind), .tx_busy_out(tx_busy),
      .last_kind_out(last_kind), .sent_cnt_out(sent_cnt));
   task chk(input [31:0] exp, input [31:0] got, input [8*8-1:0] name);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
   endtask
   // Hold the request until pready is sampled high
   task apb(input w, input [11:0] a, input [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys_in) penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1) @(posedge clk_sys_in);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task smp(input [23:0] r);
      ang = ang + {{7{r[23]}}, r[23:7]};
      s_vld <= 1'b1; s_rate <= r;
      @(posedge clk_sys_in) s_vld <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task chr(input [7:0] c);
      rx_vld <= 1'b1; rx_chr <= c;
      @(posedge clk_sys_in) rx_vld <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
   endtask
   task cmd(input [8*11-1:0] t, input integer n);
      integer j;
      for (j = n - 1; j >= 0; j = j - 1) chr(t[8*j +: 8]);
      chr(`GYOC_CHR_CR);
   endtask
   // Trigger a send, let the sender finish, fetch {count,value}
   task send(input [1:0] u);
      apb(1'b1, `GYOC_REG_CTRL, 32'h30 | u);
      // Sender shows busy one edge after the trigger is sampled
      repeat (2) @(posedge clk_sys_in);
      while (tx_busy !== 1'b0) @(posedge clk_sys_in);
      apb(1'b0, `GYOC_REG_OUT_VAL, 32'h0);
   endtask
   task test_done;
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      test_done;
   end
   initial begin
      tv[0] = 24'h000400; tv[1] = 24'hFFFD00; tv[2] = 24'h7FFF80; tv[3] = 24'hFFFFF9;
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      chk(`GYOC_MODE_INIT, mode, "mode");
      chk(1, tx_stab, "stab");
      apb(1'b1, `GYOC_REG_CTRL, 32'h200);
      chk(`GYOC_MODE_NORMAL, mode, "mode");
      apb(1'b0, 12'h024, 32'h0);
      chk(1, err, "slverr");
      send(`GYOC_UNIT_INCR);
      acc = 24'h0;
      for (i = 0; i < 3; i = i + 1) begin
         smp(tv[i]);
         acc = acc + {{7{tv[i][23]}}, tv[i][23:7]};
      end
      send(`GYOC_UNIT_INCR);
      chk({8'd3, acc}, rd, "incr");
      cmd("N", 1);
      apb(1'b1, `GYOC_REG_CTRL, 32'h31);
      smp(tv[0]);
      smp(tv[1]);
      while (tx_busy !== 1'b0) @(posedge clk_sys_in);
      send(`GYOC_UNIT_INCR);
      chk(32'h0, rd, "drop");
      send(`GYOC_UNIT_AVG);
      s = 0;
      for (i = 0; i < 4; i = i + 1) begin
         smp(tv[i]);
         s = s + $signed(tv[i]);
      end
      send(`GYOC_UNIT_AVG);
      acc = s / 4;
      chk({8'd4, acc}, rd, "avg");
      send(`GYOC_UNIT_RATE);
      c0 = rd[31:24];
      for (i = 0; i < 3; i = i + 1) smp(tv[i]);
      send(`GYOC_UNIT_RATE);
      chk({c0 + 8'd3, tv[2]}, rd, "rate");
      apb(1'b1, `GYOC_REG_FAULT, 32'h05);
      send(`GYOC_UNIT_RATE);
      apb(1'b0, `GYOC_REG_STATUS, 32'h0);
      chk(32'h05, rd, "status");
      apb(1'b1, `GYOC_REG_FAULT, 32'h0);
      send(`GYOC_UNIT_RATE);
      apb(1'b0, `GYOC_REG_STATUS, 32'h0);
      chk(32'h0, rd, "stat_clr");
      apb(1'b0, `GYOC_REG_LASTERR, 32'h0);
      chk(32'h05, rd, "lasterr");
      apb(1'b1, `GYOC_REG_TEMP, 32'h1234ABCD);
      apb(1'b0, `GYOC_REG_OUT_AUX, 32'h0);
      chk(16'hABCD, rd[15:0], "temp");
      chk(16'h1234, rd[31:16], "latency");
      send(`GYOC_UNIT_INTEG);
      send(`GYOC_UNIT_INTEG);
      chk(ang, rd[23:0], "integ");
      cmd("N", 1);
      send(`GYOC_UNIT_RATE);
      chk(`GYOC_DG_PART, last_kind, "kind_n");
      cmd("I", 1);
      send(`GYOC_UNIT_RATE);
      chk(`GYOC_DG_SERIAL, last_kind, "kind_i");
      cmd("XC", 2);
      send(`GYOC_UNIT_RATE);
      chk(`GYOC_DG_MEAS, last_kind, "kind_bad");
      cmd("X", 1);
      cmd("C", 1);
      send(`GYOC_UNIT_RATE);
      chk(`GYOC_DG_CONFIG, last_kind, "kind_c");
      cmd("n", 1);
      send(`GYOC_UNIT_RATE);
      chk(`GYOC_DG_MEAS, last_kind, "kind_lc");
      apb(1'b1, `GYOC_REG_CTRL, 32'h30);
      cmd(`GYOC_ENTRY_WORD, 11);
      chk(`GYOC_MODE_NORMAL, mode, "mid_dg");
      while (mode !== `GYOC_MODE_MAINT) @(posedge clk_sys_in);
      repeat (3) @(posedge clk_sys_in);
      chk(`GYOC_DG_INFO, last_kind, "listing");
      c0 = sent_cnt;
      send(`GYOC_UNIT_RATE);
      chk(c0, sent_cnt, "quiet");
      apb(1'b1, `GYOC_REG_CTRL, 32'hE0);
      chk(`GYOC_MODE_NORMAL, mode, "exit");
      chk(0, tx_stab, "no_stab");
      cmd("R", 1);
      chk(`GYOC_MODE_INIT, mode, "reset");
      apb(1'b1, `GYOC_REG_CTRL, 32'h200);
      cmd(`GYOC_ENTRY_WORD, 11);
      while (mode !== `GYOC_MODE_MAINT) @(posedge clk_sys_in);
      apb(1'b1, `GYOC_REG_CTRL, 32'h40);
      chk(`GYOC_MODE_INIT, mode, "to_init");
      test_done;
   end
endmodule
